// *** hw/bobe_pkg.sv ***
package bobe_pkg;

  // opcodes with a fixed encoding
  localparam logic [7:0] OP_CARRY_AND = 8'h8B;
  localparam logic [7:0] OP_CARRY_OR = 8'h6B;
  localparam logic [7:0] OP_CARRY_XOR = 8'hAB;
  localparam logic [7:0] OP_LOAD_CARRY = 8'hCB;
  localparam logic [7:0] OP_STORE_CARRY = 8'hEB;
  localparam logic [7:0] OP_INVERT_MEM_BIT = 8'h4B;
  localparam logic [7:0] OP_FORCE_ACC_BIT_HIGH = 8'h0B;
  localparam logic [7:0] OP_FORCE_ACC_BIT_LOW = 8'h2B;
  localparam logic [7:0] OP_CARRY_LOW = 8'h20;
  localparam logic [7:0] OP_CARRY_HIGH = 8'hA0;
  localparam logic [7:0] OP_PAGE_FLAG_LOW = 8'h40;
  localparam logic [7:0] OP_PAGE_FLAG_HIGH = 8'hC0;
  localparam logic [7:0] OP_OVERFLOW_LOW = 8'h80;
  localparam logic [7:0] OP_BIT_TEST_DP = 8'h0C;
  localparam logic [7:0] OP_BIT_TEST_ABS = 8'h1C;
  localparam logic [7:0] OP_TEST_THEN_MASK_OFF = 8'h5C;
  localparam logic [7:0] OP_TEST_THEN_MASK_ON = 8'h3C;
  localparam logic [7:0] OP_BRANCH_ON_CARRY_LOW = 8'h50;
  localparam logic [7:0] OP_BRANCH_ON_CARRY_HIGH = 8'hD0;
  localparam logic [7:0] OP_BRANCH_ON_ZERO_HIGH = 8'hF0;
  localparam logic [7:0] OP_BRANCH_ON_ZERO_LOW = 8'h70;
  localparam logic [7:0] OP_BRANCH_ON_NEGATIVE = 8'h90;

  // low nibbles of the bit-number-in-high-nibble groups
  localparam logic [3:0] LO_DP_BIT = 4'h1;
  localparam logic [3:0] LO_ACC_BIT_BRANCH = 4'h2;
  localparam logic [3:0] LO_DP_BIT_BRANCH = 4'h3;

  // instruction lengths in bytes
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;

  // cycle counts
  localparam logic [2:0] CYC_CARRY_AND = 3'h4;
  localparam logic [2:0] CYC_CARRY_OR = 3'h5;
  localparam logic [2:0] CYC_CARRY_XOR = 3'h5;
  localparam logic [2:0] CYC_LOAD_CARRY = 3'h4;
  localparam logic [2:0] CYC_STORE_CARRY = 3'h6;
  localparam logic [2:0] CYC_INVERT_MEM_BIT = 3'h5;
  localparam logic [2:0] CYC_DP_BIT = 3'h4;
  localparam logic [2:0] CYC_ACC_BIT = 3'h2;
  localparam logic [2:0] CYC_FLAG_OP = 3'h2;
  localparam logic [2:0] CYC_BIT_TEST_DP = 3'h4;
  localparam logic [2:0] CYC_BIT_TEST_ABS = 3'h5;
  localparam logic [2:0] CYC_TEST_MASK = 3'h6;
  localparam logic [2:0] CYC_ACC_BRANCH = 3'h4;
  localparam logic [2:0] CYC_ACC_BRANCH_TAKEN = 3'h6;
  localparam logic [2:0] CYC_DP_BRANCH = 3'h5;
  localparam logic [2:0] CYC_DP_BRANCH_TAKEN = 3'h7;
  localparam logic [2:0] CYC_REL_BRANCH = 3'h2;
  localparam logic [2:0] CYC_REL_BRANCH_TAKEN = 3'h4;
  localparam logic [2:0] CYC_ILLEGAL = 3'h1;

  // memory-bit operand: address in the low bits, bit number on top
  localparam int MBIT_ADDR_W = 13;

  // register offsets (low five address bits)
  localparam logic [4:0] OFF_CMD = 5'h00;
  localparam logic [4:0] OFF_OPERAND = 5'h04;
  localparam logic [4:0] OFF_ACC = 5'h08;
  localparam logic [4:0] OFF_FLAGS = 5'h0C;
  localparam logic [4:0] OFF_PC = 5'h10;
  localparam logic [4:0] OFF_STATUS = 5'h14;

  // field positions
  localparam int CMD_INV_POS = 8;
  localparam int ST_BUSY_POS = 0;
  localparam int ST_ILLEGAL_POS = 1;
  localparam int ST_TAKEN_POS = 2;
  localparam int ST_CYC_POS = 8;

  // reset values
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [4:0] RST_FLAGS = 5'h00;

  typedef struct packed {
    logic inv;
    logic [7:0] opcode;
    logic [15:0] oper;
  } bobe_instr_t;

  typedef struct packed {
    logic n;
    logic v;
    logic g;
    logic z;
    logic c;
  } bobe_flags_t;

  typedef enum logic [1:0] {
    BOBE_IDLE = 2'b01,
    BOBE_RUN = 2'b10
  } bobe_state_t;

endpackage : bobe_pkg

// *** hw/bobe_exec.sv ***
// How it works
// RULE1 - 8B: carry ANDs memory bit or its complement
// RULE2 - 6B: carry ORs memory bit or its complement
// RULE3 - AB: carry XORs memory bit or complement
// RULE4 - CB: carry loads memory bit or complement
// RULE5 - EB: carry written into memory bit
// RULE6 - 4B: memory bit inverted, flags kept
// RULE7 - x1: direct-page bit forced high
// RULE8 - y1: direct-page bit forced low
// RULE9 - 0B/2B: accumulator bit set or cleared
// RULE10 - 20 clears carry, A0 sets carry
// RULE11 - 40 clears page flag, C0 sets it
// RULE12 - 80 clears overflow in two cycles
// RULE13 - bit test sets zero, negative, overflow
// RULE14 - 5C: flags from A-M, M masked off
// RULE15 - 3C: flags from A-M, M masked on
// RULE16 - branch when tested bit is zero
// RULE17 - branch when tested bit is one
// RULE18 - branch on carry clear or set
// RULE19 - branch on zero set or clear
// RULE20 - 90 branches when negative is one
// RULE21 - taken branch uses the larger count
// RULE22 - signed offset added to next address
// RULE23 - bit number comes from high nibble
//
// Implementation choices: the address map and the APB register port.
module bobe_exec
  import bobe_pkg::*;
#(
  parameter int MEM_WORDS = 512
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [$clog2(MEM_WORDS)+2:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  localparam int IDX_W = $clog2(MEM_WORDS);
  localparam int ADDR_W = IDX_W + 3;
  // the direct page needs the page flag on top of a byte address
  if (MEM_WORDS < 512 || (MEM_WORDS & (MEM_WORDS - 1)) != 0) begin : g_bad_depth
    $error("MEM_WORDS must be a power of two of at least 512");
  end
  logic [7:0] mem [MEM_WORDS];
  bobe_instr_t instr;
  bobe_flags_t flags;
  bobe_state_t state;
  logic [7:0] acc;
  logic [15:0] pc;
  logic [2:0] cnt;
  logic lastIllegal;
  logic lastTaken;
  logic [2:0] lastCycles;
  logic [3:0] opLo;
  logic [2:0] bitSel;
  logic highForm;
  logic [IDX_W-1:0] dpIdx;
  logic [IDX_W-1:0] mbIdx;
  logic [IDX_W-1:0] absIdx;
  logic [7:0] dpByte;
  logic [7:0] mbByte;
  logic [7:0] absByte;
  logic [7:0] testByte;
  logic [7:0] diff;
  logic [2:0] mbBit;
  logic mbVal;
  logic legal;
  logic isBranch;
  logic cond;
  logic taken;
  logic [1:0] len;
  logic [2:0] cycBase;
  logic [2:0] cycTaken;
  logic [2:0] cycNeed;
  logic [7:0] rel;
  logic [7:0] next_acc;
  bobe_flags_t next_flags;
  logic [15:0] next_pc;
  logic memWe;
  logic [IDX_W-1:0] memIdx;
  logic [7:0] memData;
  logic finish;
  always_comb begin
    opLo = instr.opcode[3:0];
    bitSel = instr.opcode[7:5]; // RULE23
    highForm = !instr.opcode[4];
    dpIdx = IDX_W'({flags.g, instr.oper[7:0]});
    mbIdx = IDX_W'(instr.oper[MBIT_ADDR_W-1:0]);
    mbBit = instr.oper[15:MBIT_ADDR_W];
    absIdx = IDX_W'(instr.oper);
    dpByte = mem[dpIdx];
    mbByte = mem[mbIdx];
    absByte = mem[absIdx];
    mbVal = mbByte[mbBit];
    testByte = (instr.opcode == OP_BIT_TEST_DP) ? dpByte : absByte;
    diff = acc - absByte;
    legal = 1'b1;
    isBranch = 1'b0;
    cond = 1'b0;
    len = LEN_1;
    cycBase = CYC_ILLEGAL;
    cycTaken = CYC_ILLEGAL;
    rel = instr.oper[7:0];
    next_acc = acc;
    next_flags = flags;
    memWe = 1'b0;
    memIdx = mbIdx;
    memData = mbByte;
    if (opLo == LO_DP_BIT) begin
      len = LEN_2;
      cycBase = CYC_DP_BIT;
      memWe = 1'b1;
      memIdx = dpIdx;
      memData = dpByte;
      memData[bitSel] = highForm; // RULE7 RULE8
    end else if (opLo == LO_ACC_BIT_BRANCH) begin
      len = LEN_2;
      isBranch = 1'b1;
      cycBase = CYC_ACC_BRANCH;
      cycTaken = CYC_ACC_BRANCH_TAKEN;
      cond = (acc[bitSel] == highForm); // RULE16 RULE17
    end else if (opLo == LO_DP_BIT_BRANCH) begin
      len = LEN_3;
      isBranch = 1'b1;
      cycBase = CYC_DP_BRANCH;
      cycTaken = CYC_DP_BRANCH_TAKEN;
      rel = instr.oper[15:8];
      cond = (dpByte[bitSel] == highForm); // RULE16 RULE17
    end else begin
      case (instr.opcode)
        OP_CARRY_AND: begin
          len = LEN_3;
          cycBase = CYC_CARRY_AND;
          next_flags.c = flags.c & (mbVal ^ instr.inv); // RULE1
        end
        OP_CARRY_OR: begin
          len = LEN_3;
          cycBase = CYC_CARRY_OR;
          next_flags.c = flags.c | (mbVal ^ instr.inv); // RULE2
        end
        OP_CARRY_XOR: begin
          len = LEN_3;
          cycBase = CYC_CARRY_XOR;
          next_flags.c = flags.c ^ (mbVal ^ instr.inv); // RULE3
        end
        OP_LOAD_CARRY: begin
          len = LEN_3;
          cycBase = CYC_LOAD_CARRY;
          next_flags.c = mbVal ^ instr.inv; // RULE4
        end
        OP_STORE_CARRY: begin
          len = LEN_3;
          cycBase = CYC_STORE_CARRY;
          memWe = 1'b1;
          memData[mbBit] = flags.c; // RULE5
        end
        OP_INVERT_MEM_BIT: begin
          len = LEN_3;
          cycBase = CYC_INVERT_MEM_BIT;
          memWe = 1'b1;
          memData[mbBit] = !mbVal; // RULE6
        end
        OP_FORCE_ACC_BIT_HIGH: begin
          len = LEN_2;
          cycBase = CYC_ACC_BIT;
          next_acc[instr.oper[2:0]] = 1'b1; // RULE9
        end
        OP_FORCE_ACC_BIT_LOW: begin
          len = LEN_2;
          cycBase = CYC_ACC_BIT;
          next_acc[instr.oper[2:0]] = 1'b0; // RULE9
        end
        OP_CARRY_LOW, OP_CARRY_HIGH: begin
          cycBase = CYC_FLAG_OP;
          next_flags.c = (instr.opcode == OP_CARRY_HIGH); // RULE10
        end
        OP_PAGE_FLAG_LOW, OP_PAGE_FLAG_HIGH: begin
          cycBase = CYC_FLAG_OP;
          next_flags.g = (instr.opcode == OP_PAGE_FLAG_HIGH); // RULE11
        end
        OP_OVERFLOW_LOW: begin
          cycBase = CYC_FLAG_OP;
          next_flags.v = 1'b0; // RULE12
        end
        OP_BIT_TEST_DP, OP_BIT_TEST_ABS: begin
          len = (instr.opcode == OP_BIT_TEST_DP) ? LEN_2 : LEN_3;
          cycBase = (instr.opcode == OP_BIT_TEST_DP) ? CYC_BIT_TEST_DP : CYC_BIT_TEST_ABS;
          next_flags.z = ((acc & testByte) == 8'h00); // RULE13
          next_flags.n = testByte[7]; // RULE13
          next_flags.v = testByte[6]; // RULE13
        end
        OP_TEST_THEN_MASK_OFF: begin
          len = LEN_3;
          cycBase = CYC_TEST_MASK;
          next_flags.n = diff[7]; // RULE14
          next_flags.z = (diff == 8'h00); // RULE14
          memWe = 1'b1;
          memIdx = absIdx;
          memData = absByte & ~acc; // RULE14
        end
        OP_TEST_THEN_MASK_ON: begin
          len = LEN_3;
          cycBase = CYC_TEST_MASK;
          next_flags.n = diff[7]; // RULE15
          next_flags.z = (diff == 8'h00); // RULE15
          memWe = 1'b1;
          memIdx = absIdx;
          memData = absByte | acc; // RULE15
        end
        OP_BRANCH_ON_CARRY_LOW, OP_BRANCH_ON_CARRY_HIGH: begin
          len = LEN_2;
          isBranch = 1'b1;
          cycBase = CYC_REL_BRANCH;
          cycTaken = CYC_REL_BRANCH_TAKEN;
          cond = flags.c == (instr.opcode == OP_BRANCH_ON_CARRY_HIGH); // RULE18
        end
        OP_BRANCH_ON_ZERO_HIGH, OP_BRANCH_ON_ZERO_LOW: begin
          len = LEN_2;
          isBranch = 1'b1;
          cycBase = CYC_REL_BRANCH;
          cycTaken = CYC_REL_BRANCH_TAKEN;
          cond = flags.z == (instr.opcode == OP_BRANCH_ON_ZERO_HIGH); // RULE19
        end
        OP_BRANCH_ON_NEGATIVE: begin
          len = LEN_2;
          isBranch = 1'b1;
          cycBase = CYC_REL_BRANCH;
          cycTaken = CYC_REL_BRANCH_TAKEN;
          cond = flags.n; // RULE20
        end
        default: begin
          legal = 1'b0;
        end
      endcase
    end
    taken = isBranch & cond;
    cycNeed = taken ? cycTaken : cycBase; // RULE21
    next_pc = pc + 16'(len) + (taken ? {{8{rel[7]}}, rel} : 16'h0000); // RULE22
    finish = (state == BOBE_RUN) && (cnt == cycNeed - 3'h1);
  end
  // apb slave: one wait state so that read data and error come from flops
  logic access;
  logic commit;
  logic memSel;
  logic regSel;
  logic [4:0] off;
  logic busy;
  logic wrOk;
  logic errNow;
  logic [31:0] rdata;
  logic [31:0] laneMask;
  logic [31:0] regOld;
  logic [31:0] merged;
  always_comb begin
    access = psel & penable;
    commit = access & pready;
    busy = (state == BOBE_RUN);
    off = paddr[4:0];
    memSel = paddr[ADDR_W-1] && (paddr[1:0] == 2'h0);
    regSel = !paddr[ADDR_W-1] && (paddr[ADDR_W-2:5] == '0) &&
             (off == OFF_CMD || off == OFF_OPERAND || off == OFF_ACC ||
              off == OFF_FLAGS || off == OFF_PC || off == OFF_STATUS);
    // state is frozen while an instruction runs, so writes then are refused, except writes to the status register
    errNow = !(memSel || regSel) || (pwrite && busy && !(regSel && off == OFF_STATUS));
    // the error flop was latched in the previous cycle; it gates the commit
    wrOk = commit & pwrite & !pslverr;
    for (int i = 0; i < 4; i++) begin
      laneMask[8*i +: 8] = {8{pstrb[i]}};
    end
    case (off)
      OFF_CMD: regOld = {23'h00_0000, instr.inv, instr.opcode};
      OFF_OPERAND: regOld = {16'h0000, instr.oper};
      OFF_ACC: regOld = {24'h00_0000, acc};
      OFF_FLAGS: regOld = {27'h000_0000, flags};
      OFF_PC: regOld = {16'h0000, pc};
      default: regOld = 32'h0000_0000;
    endcase
    if (memSel) begin
      regOld = {24'h00_0000, mem[paddr[ADDR_W-2:2]]};
    end
    merged = (regOld & ~laneMask) | (pwdata & laneMask);
    rdata = regOld;
    if (regSel && off == OFF_STATUS) begin
      rdata = 32'h0000_0000;
      rdata[ST_BUSY_POS] = busy;
      rdata[ST_ILLEGAL_POS] = lastIllegal;
      rdata[ST_TAKEN_POS] = lastTaken;
      rdata[ST_CYC_POS +: 3] = lastCycles;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access & !pready;
      if (access & !pready) begin
        pslverr <= errNow;
        prdata <= (pwrite || errNow) ? 32'h0000_0000 : rdata;
      end else begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
      end
    end
  end
  logic start;
  assign start = wrOk && regSel && off == OFF_CMD && pstrb[0];
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      instr <= '0;
    end else if (wrOk && regSel && off == OFF_CMD) begin
      instr.opcode <= merged[7:0];
      instr.inv <= merged[CMD_INV_POS];
    end else if (wrOk && regSel && off == OFF_OPERAND) begin
      instr.oper <= merged[15:0];
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= BOBE_IDLE;
      cnt <= 3'h0;
    end else begin
      case (state)
        BOBE_IDLE: begin
          cnt <= 3'h0;
          if (start) begin
            state <= BOBE_RUN;
          end
        end
        BOBE_RUN: begin
          cnt <= cnt + 3'h1;
          if (finish) begin
            state <= BOBE_IDLE;
            cnt <= 3'h0;
          end
        end
        default: begin
          state <= BOBE_IDLE;
          cnt <= 3'h0;
        end
      endcase
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lastIllegal <= 1'b0;
      lastTaken <= 1'b0;
      lastCycles <= 3'h0;
    end else if (finish) begin
      lastIllegal <= !legal;
      lastTaken <= taken;
      lastCycles <= cycNeed;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc <= RST_ACC;
    end else if (wrOk && regSel && off == OFF_ACC) begin
      acc <= merged[7:0];
    end else if (finish && legal) begin
      acc <= next_acc;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags <= RST_FLAGS;
    end else if (wrOk && regSel && off == OFF_FLAGS) begin
      flags <= merged[4:0];
    end else if (finish && legal) begin
      flags <= next_flags;
    end
  end
  // an unknown opcode leaves the program counter on itself
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc <= RST_PC;
    end else if (wrOk && regSel && off == OFF_PC) begin
      pc <= merged[15:0];
    end else if (finish && legal) begin
      pc <= next_pc; // RULE22
    end
  end
  // data memory has no reset; software must load what it tests
  always_ff @(posedge mclk) begin
    if (wrOk && memSel) begin
      mem[paddr[ADDR_W-2:2]] <= merged[7:0];
    end else if (finish && legal && memWe) begin
      mem[memIdx] <= memData;
    end
  end
endmodule : bobe_exec

// *** tb/bobe_exec_checker.sv ***
module bobe_exec_checker
  import bobe_pkg::*;
#(
  parameter int MEM_WORDS = 512
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [$clog2(MEM_WORDS)+2:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AW = $clog2(MEM_WORDS) + 3;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [3:0] busyCnt;

  // branches and illegal codes return 0, so no check: branch length depends on whether it is taken, illegal codes take one cycle
  function automatic logic [3:0] opCycles(input logic [7:0] op);
    case (op)
      8'h8B, 8'hCB, 8'h0C: return 4'h4;
      8'h6B, 8'hAB, 8'h4B, 8'h1C: return 4'h5;
      8'hEB, 8'h5C, 8'h3C: return 4'h6;
      8'h0B, 8'h2B, 8'h20, 8'hA0, 8'h40, 8'hC0, 8'h80: return 4'h2;
      default: return (op[3:0] == 4'h1) ? 4'h4 : 4'h0;
    endcase
  endfunction : opCycles

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busyCnt <= 4'h0;
    end else if (pready && !pslverr && pwrite && paddr == '0 && pstrb[0]) begin
      busyCnt <= opCycles(pwdata[7:0]);
    end else if (busyCnt != 4'h0) begin
      busyCnt <= busyCnt - 4'h1;
    end
  end

  sequence accStart;
    psel && !penable ##1 psel && penable;
  endsequence

  a_ready_wait: assert property (accStart |-> !pready ##1 pready) else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata not zero when idle");
  a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("pready without access");
  a_misalign_err: assert property (accStart ##0 (paddr[AW-1] && paddr[1:0] != 2'h0) |-> ##1 pslverr)
    else $error("misaligned memory access accepted");
  a_busy_refuse: assert property (accStart ##0 (pwrite && paddr != AW'(OFF_STATUS) && busyCnt != 4'h0)
    |-> ##1 pslverr) else $error("write accepted while busy");
  a_status_free: assert property (accStart ##0 (pwrite && paddr == AW'(OFF_STATUS)) |-> ##1 !pslverr)
    else $error("status write refused");
endmodule : bobe_exec_checker

bind bobe_exec bobe_exec_checker #(.MEM_WORDS(MEM_WORDS)) i_chk (
  .mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// *** tb/tb.sv ***
module tb
  import bobe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} bobe_note_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int nMismatch = 0;
  int nTests = 0;
  int cyc = 0;
  bobe_note_t notes[$];
  logic [7:0] mA;
  logic [7:0] mM;
  bobe_flags_t mF;
  logic [15:0] mP;
  logic [7:0] ops [29] = '{8'h8B, 8'h6B, 8'hAB, 8'hCB, 8'hEB, 8'h4B, 8'h01, 8'h11, 8'h0B, 8'h2B, 8'h20, 8'hA0,
    8'h40, 8'hC0, 8'h80, 8'h0C, 8'h1C, 8'h5C, 8'h3C, 8'h02, 8'h12, 8'h03, 8'h13, 8'h50, 8'hD0, 8'hF0, 8'h70,
    8'h90, 8'hFF};

  bobe_exec i_dut (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    forever #2 mclk = ~mclk;
  end

  task automatic closeOut();
    if (nMismatch == 0 && nTests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : closeOut

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      nMismatch++;
      closeOut();
    end
  end

  always @(posedge mclk) begin
    bobe_note_t x;
    if (pready === 1'b1) begin
      x = notes.pop_front();
      nTests++;
      if ((prdata & x.m) !== (x.d & x.m) || pslverr !== x.e) begin
        nMismatch++;
        $display("BAD %0t got %h/%b exp %h/%b", $time, prdata, pslverr, x.d, x.e);
      end
    end
  end

  // psel stays up after the answer so a following access runs back to back
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x,
    input logic [31:0] m, input logic e);
    notes.push_back('{x, m, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    penable <= 1'b0;
  endtask : acc

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 32'h0000_0000, 32'hffff_ffff, 1'b0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m = 32'hffff_ffff);
    acc(1'b0, a, 32'h0000_0000, x, m, 1'b0);
  endtask : rd

  task automatic idle(input int n);
    psel <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask : idle

  function automatic logic [11:0] ra(input logic [4:0] off);
    return {7'h00, off};
  endfunction : ra

  task automatic run(input logic [7:0] op, input logic iv);
    logic [15:0] o;
    logic [8:0] ix;
    logic [7:0] rel;
    logic [7:0] t;
    logic [3:0] n;
    logic [1:0] len;
    logic tk;
    logic br;
    logic bm;
    o = 16'($urandom);
    mA = 8'($urandom);
    mF = 5'($urandom);
    mP = 16'($urandom);
    mM = 8'($urandom);
    ix = (op[3:0] == 4'hB || (op[4] && op[3:0] == 4'hC)) ? o[8:0] : {mF.g, o[7:0]};
    wr(ra(OFF_ACC), 32'(mA));
    wr(ra(OFF_FLAGS), 32'(mF));
    wr(ra(OFF_PC), 32'(mP));
    wr(ra(OFF_OPERAND), 32'(o));
    wr({1'b1, ix, 2'b00}, 32'(mM));
    bm = mM[o[15:13]] ^ iv;
    t = mA - mM;
    rel = (op[3:0] == 4'h3) ? o[15:8] : o[7:0];
    len = 2'h3;
    tk = 1'b0;
    br = 1'b0;
    n = 4'h0;
    case (op)
      8'h8B: begin mF.c = mF.c & bm; n = 4'h4; end
      8'h6B: begin mF.c = mF.c | bm; n = 4'h5; end
      8'hAB: begin mF.c = mF.c ^ bm; n = 4'h5; end
      8'hCB: begin mF.c = bm; n = 4'h4; end
      8'hEB: begin mM[o[15:13]] = mF.c; n = 4'h6; end
      8'h4B: begin mM[o[15:13]] = !mM[o[15:13]]; n = 4'h5; end
      8'h0B, 8'h2B: begin mA[o[2:0]] = !op[5]; n = 4'h2; len = 2'h2; end
      8'h20, 8'hA0: begin mF.c = op[7]; n = 4'h2; len = 2'h1; end
      8'h40, 8'hC0: begin mF.g = op[7]; n = 4'h2; len = 2'h1; end
      8'h80: begin mF.v = 1'b0; n = 4'h2; len = 2'h1; end
      8'h0C, 8'h1C: begin
        mF.z = (mA & mM) == 8'h00;
        mF.n = mM[7];
        mF.v = mM[6];
        n = op[4] ? 4'h5 : 4'h4;
        len = op[4] ? 2'h3 : 2'h2;
      end
      8'h5C, 8'h3C: begin
        mF.n = t[7];
        mF.z = t == 8'h00;
        mM = op[6] ? (mM & ~mA) : (mM | mA);
        n = 4'h6;
      end
      8'h50, 8'hD0: begin tk = mF.c == op[7]; br = 1'b1; end
      8'hF0, 8'h70: begin tk = mF.z == op[7]; br = 1'b1; end
      8'h90: begin tk = mF.n; br = 1'b1; end
      default: begin
        case (op[3:0])
          4'h1: begin mM[op[7:5]] = !op[4]; n = 4'h4; len = 2'h2; end
          4'h2: begin tk = mA[op[7:5]] == !op[4]; br = 1'b1; n = tk ? 4'h6 : 4'h4; len = 2'h2; end
          4'h3: begin tk = mM[op[7:5]] == !op[4]; br = 1'b1; n = tk ? 4'h7 : 4'h5; end
          default: begin n = 4'h1; len = 2'h0; end
        endcase
      end
    endcase
    if (br && n == 4'h0) n = tk ? 4'h4 : 4'h2;
    if (br && op[3:0] == 4'h0) len = 2'h2;
    mP = mP + 16'(len) + (tk ? {{8{rel[7]}}, rel} : 16'h0000);
    wr(ra(OFF_CMD), {23'h00_0000, iv, op});
    // a back-to-back write lands inside every busy window of two cycles or more
    if (n > 4'h1) acc(1'b1, ra(OFF_ACC), 32'h0000_00ff, 32'h0000_0000, 32'hffff_ffff, 1'b1);
    idle(8);
    rd(ra(OFF_STATUS), {21'h0, n[2:0], 5'h00, tk, n == 4'h1, 1'b0}, {21'h0, 3'h7, 5'h00, br, 2'h3});
    rd(ra(OFF_ACC), 32'(mA));
    rd(ra(OFF_FLAGS), 32'(mF));
    rd(ra(OFF_PC), 32'(mP));
    rd({1'b1, ix, 2'b00}, 32'(mM));
  endtask : run

  initial begin
    logic [7:0] op;
    void'($urandom(32'h076e_0165));
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    for (int p = 0; p < 6; p++) begin
      for (int k = 0; k < 29; k++) begin
        op = ops[k];
        if (op[3:0] inside {4'h1, 4'h2, 4'h3}) op[7:5] = 3'($urandom);
        run(op, (op inside {8'h8B, 8'h6B, 8'hAB, 8'hCB}) ? 1'($urandom) : 1'b0);
      end
    end
    acc(1'b0, 12'h400, 32'h0000_0000, 32'h0000_0000, 32'hffff_ffff, 1'b1);
    acc(1'b0, 12'h802, 32'h0000_0000, 32'h0000_0000, 32'hffff_ffff, 1'b1);
    wr(ra(OFF_STATUS), 32'h0000_0007);
    idle(4);
    closeOut();
  end
endmodule : tb
